// ===== smc_host.sv
// Host model: drives the plain register port of smc_top
// Assumes its tasks are called just after a rising core_clk edge
`timescale 1ns/1ps
module smc_host (
    input  wire logic        core_clk,
    output logic      [3:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    // Quiet port at time zero
    initial begin
        addr  = 4'h0;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // One-cycle write, then a gap; callers hand only in-range time fields
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        @(posedge core_clk);
    endtask
    // One-cycle read; data stands only in the next cycle, so take it there
    task automatic get(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        addr <= ~a;
        @(posedge core_clk);
        d = rdata;
    endtask
endmodule

// ===== smc_pkg.sv
// Package for the system misc control block: register map and field layout
// Assumes a single 25 MHz core clock and a plain strobe register port
package smc_pkg;
    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] ADDR_TIME_SM       = 4'h0;
    localparam logic [3:0] ADDR_TIME_HD       = 4'h1;
    localparam logic [3:0] ADDR_SPS_CTL       = 4'h2;
    localparam logic [3:0] ADDR_CHIP_CTL      = 4'h3;
    localparam logic [3:0] ADDR_HW_CFG0       = 4'h4;
    localparam logic [3:0] ADDR_HW_CFG2       = 4'h5;
    localparam logic [3:0] ADDR_INT_MASK      = 4'h6;
    localparam logic [3:0] ADDR_STATUS        = 4'h7;
    localparam logic [3:0] ADDR_MODE          = 4'h8;
    // Time field widths and limits
    localparam int         SEC_W              = 6;
    localparam int         MIN_W              = 6;
    localparam int         HR_W               = 5;
    localparam int         DAY_W              = 11;
    localparam logic [5:0] SEC_MAX            = 6'h3B;
    localparam logic [5:0] MIN_MAX            = 6'h3B;
    localparam logic [4:0] HR_MAX             = 5'h17;
    // One second at 25 MHz, counted on the main clock gated by the aux-oscillator tick
    localparam int         CORE_HZ            = 25_000_000;
    localparam int         TICK_HZ            = 1;
    localparam int         SEC_CYCLES         = CORE_HZ / TICK_HZ;
    // Special output control field positions
    localparam int         SPS_VAL0_BIT       = 0;
    localparam int         SPS_VAL1_BIT       = 1;
    localparam int         SPS_MODE_LSB       = 2;
    localparam int         SPS_POS_LSB        = 5;
    // Output mode codes
    localparam logic [2:0] SPS_MODE_GPO       = 3'h0;
    localparam logic [2:0] SPS_MODE_SPKR      = 3'h1;
    localparam logic [2:0] SPS_MODE_EXTADDR   = 3'h2;
    localparam logic [2:0] SPS_MODE_STATUS    = 3'h3;
    // Config bit positions
    localparam int         CFG0_OSC_BIT       = 0;
    localparam int         CFG0_RTC_EN_BIT    = 1;
    localparam int         CFG2_PPM_BIT       = 0;
    localparam int         CFG2_AUDIO_GRADE_DRAM_BIT      = 1;
    localparam int         CFG2_APP_BIT       = 2;
    // Status layout
    localparam int         STAT_W             = 16;
    localparam int         STAT_RDY_BIT       = 15;
    localparam int         STAT_ABT_BIT       = 0;
    localparam logic [15:0] ZERO16            = 16'h0000;
    // Device modes
    typedef enum logic [1:0] {SMC_RESET, SMC_ACTIVE, SMC_PDOWN} smc_mode_t;
endpackage

// ===== smc_top.sv
// System misc control: elapsed-time clock, special output mux, mode sequencing, interrupt
// Assumes aux_osc_run and status come from logic or pins outside this clock domain
//
// Overview of operation
// - Seconds, minutes, hours, days elapsed-time counters
// - Count only with aux oscillator and enable
// - Mode field selects special output function
// - Status mode shows bits pos and pos+1
// - Ready bit never reaches special outputs
// - Reset mode clears config, halts activity
// - Address lines weak low until used
// - Config registers accessible during reset mode
// - First register access enters active mode
// - Power-down bit enters power-down mode
// - Power-down stops oscillator, releases control lines
// - Refresh may continue with aux oscillator
// - Any access in power-down returns active
// - Status bit changes raise an interrupt
// - Mask per bit, abort never masked
`timescale 1ns/1ps
module smc_top
    import smc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        aux_osc_run,
    input  wire logic [15:0] status_in,
    input  wire logic        spkr_status,
    input  wire logic [1:0]  prompt_ext_addr,
    input  wire logic        mem_addr_used,
    output logic             special_output_first,
    output logic             special_output_second,
    output logic             irq,
    output logic             main_osc_en,
    output logic             core_run,
    output logic             mem_active,
    output logic             mem_ctl_release,
    output logic             memory_address_lines_weak_low,
    output logic [1:0]       dev_mode
);

    // Synchronisers for inputs from outside the domain
    logic        osc_s1;
    logic        osc_s2;
    logic [15:0] stat_s1;
    logic [15:0] stat_s2;
    logic        spk_s1;
    logic        spk_s2;
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic        mau_s1;
    logic        mau_s2;

    // Register state
    smc_mode_t   mode;
    smc_mode_t   next_mode;
    logic [5:0]  sec;
    logic [5:0]  next_sec;
    logic [5:0]  mins;
    logic [5:0]  next_mins;
    logic [4:0]  hrs;
    logic [4:0]  next_hrs;
    logic [10:0] days;
    logic [10:0] next_days;
    logic [24:0] tick;
    logic [24:0] next_tick;
    logic [8:0]  sps_ctl;
    logic [8:0]  next_sps_ctl;
    logic        pd_bit;
    logic        next_pd_bit;
    logic [1:0]  hw_cfg0;
    logic [1:0]  next_hw_cfg0;
    logic [2:0]  hw_cfg2;
    logic [2:0]  next_hw_cfg2;
    logic [15:0] int_mask;
    logic [15:0] next_int_mask;
    logic [15:0] stat_old;
    logic [15:0] next_rdata;
    logic        next_sp0;
    logic        next_sp1;
    logic        next_irq;
    logic        any_access;
    logic [15:0] changed;

    // Status bit picker that hides the ready bit
    function automatic logic pick_status(input logic [15:0] s, input logic [4:0] idx);
        logic r;
        r = 1'b0;
        if (idx < 5'(STAT_W) && idx != 5'(STAT_RDY_BIT)) begin
            r = s[idx[3:0]];
        end
        return r;
    endfunction

    // Two-flop synchronisers; first stage only feeds the second
    always_ff @(posedge core_clk) begin
        osc_s1  <= aux_osc_run;
        osc_s2  <= osc_s1;
        stat_s1 <= status_in;
        stat_s2 <= stat_s1;
        spk_s1  <= spkr_status;
        spk_s2  <= spk_s1;
        ext_s1  <= prompt_ext_addr;
        ext_s2  <= ext_s1;
        mau_s1  <= mem_addr_used;
        mau_s2  <= mau_s1;
    end

    assign any_access = wr | rd;
    assign changed    = stat_s2 ^ stat_old;

    // Next-state logic for mode, registers, time clock and outputs
    always_comb begin
        next_mode     = mode;
        next_sec      = sec;
        next_mins     = mins;
        next_hrs      = hrs;
        next_days     = days;
        next_tick     = tick;
        next_sps_ctl  = sps_ctl;
        next_pd_bit   = pd_bit;
        next_hw_cfg0  = hw_cfg0;
        next_hw_cfg2  = hw_cfg2;
        next_int_mask = int_mask;
        next_rdata    = ZERO16;
        next_sp0      = 1'b0;
        next_sp1      = 1'b0;
        next_irq      = 1'b0;

        // Mode sequencing
        case (mode)
            SMC_RESET: begin
                if (any_access) begin
                    next_mode = SMC_ACTIVE;
                end
            end
            SMC_ACTIVE: begin
                if (pd_bit) begin
                    next_mode = SMC_PDOWN;
                end
            end
            SMC_PDOWN: begin
                if (any_access) begin
                    next_mode   = SMC_ACTIVE;
                    next_pd_bit = 1'b0;
                end
            end
            default: next_mode = SMC_RESET;
        endcase

        // Time clock; the host keeps values in range, so wraps only compare equality
        if (osc_s2 && hw_cfg0[CFG0_OSC_BIT] && hw_cfg0[CFG0_RTC_EN_BIT]) begin
            if (tick == 25'(SEC_CYCLES - 1)) begin
                next_tick = '0;
                if (sec == SEC_MAX) begin
                    next_sec = '0;
                    if (mins == MIN_MAX) begin
                        next_mins = '0;
                        if (hrs == HR_MAX) begin
                            next_hrs  = '0;
                            next_days = days + 11'd1;
                        end else begin
                            next_hrs = hrs + 5'd1;
                        end
                    end else begin
                        next_mins = mins + 6'd1;
                    end
                end else begin
                    next_sec = sec + 6'd1;
                end
            end else begin
                next_tick = tick + 25'd1;
            end
        end

        // Register writes; all but the power-down bit of ADDR_CHIP_CTL stay open in reset mode
        if (wr) begin
            if (addr == ADDR_TIME_SM) begin
                next_sec  = wdata[5:0];
                next_mins = wdata[11:6];
                next_tick = '0;
            end else if (addr == ADDR_TIME_HD) begin
                next_hrs  = wdata[4:0];
                next_days = wdata[15:5];
                next_tick = '0;
            end else if (addr == ADDR_SPS_CTL) begin
                next_sps_ctl = wdata[8:0];
            end else if (addr == ADDR_CHIP_CTL) begin
                next_pd_bit = wdata[0] && (mode != SMC_RESET);
            end else if (addr == ADDR_HW_CFG0) begin
                next_hw_cfg0 = wdata[1:0];
            end else if (addr == ADDR_HW_CFG2) begin
                next_hw_cfg2 = wdata[2:0];
            end else if (addr == ADDR_INT_MASK) begin
                next_int_mask = wdata;
            end
        end

        // Register reads; unmapped addresses read zero
        if (rd) begin
            if (addr == ADDR_TIME_SM) begin
                next_rdata = {4'h0, mins, sec};
            end else if (addr == ADDR_TIME_HD) begin
                next_rdata = {days, hrs};
            end else if (addr == ADDR_SPS_CTL) begin
                next_rdata = {7'h00, sps_ctl};
            end else if (addr == ADDR_CHIP_CTL) begin
                next_rdata = {15'h0000, pd_bit};
            end else if (addr == ADDR_HW_CFG0) begin
                next_rdata = {14'h0000, hw_cfg0};
            end else if (addr == ADDR_HW_CFG2) begin
                next_rdata = {13'h0000, hw_cfg2};
            end else if (addr == ADDR_INT_MASK) begin
                next_rdata = int_mask;
            end else if (addr == ADDR_STATUS) begin
                next_rdata = stat_s2;
            end else if (addr == ADDR_MODE) begin
                next_rdata = {14'h0000, mode};
            end
        end

        // Special output mux
        case (sps_ctl[SPS_MODE_LSB +: 3])
            SPS_MODE_GPO: begin
                next_sp0 = sps_ctl[SPS_VAL0_BIT];
                next_sp1 = sps_ctl[SPS_VAL1_BIT];
            end
            SPS_MODE_SPKR: begin
                next_sp0 = spk_s2;
                next_sp1 = 1'b0;
            end
            SPS_MODE_EXTADDR: begin
                next_sp0 = ext_s2[0];
                next_sp1 = ext_s2[1];
            end
            SPS_MODE_STATUS: begin
                next_sp0 = pick_status(stat_s2, {1'b0, sps_ctl[SPS_POS_LSB +: 4]});
                next_sp1 = pick_status(stat_s2, {1'b0, sps_ctl[SPS_POS_LSB +: 4]} + 5'd1);
            end
            default: begin
                next_sp0 = 1'b0;
                next_sp1 = 1'b0;
            end
        endcase

        // Interrupt on any status change of an enabled bit; abort always enabled
        next_irq = |(changed & (int_mask | (16'h0001 << STAT_ABT_BIT)));
    end

    // Registered state; reset mode clears configuration
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode                  <= SMC_RESET;
            sec                   <= '0;
            mins                  <= '0;
            hrs                   <= '0;
            days                  <= '0;
            tick                  <= '0;
            sps_ctl               <= '0;
            pd_bit                <= 1'b0;
            hw_cfg0               <= '0;
            hw_cfg2               <= '0;
            int_mask              <= '0;
            stat_old              <= stat_s2; // Track live status so no false edge follows reset
            rdata                 <= '0;
            special_output_first  <= 1'b0;
            special_output_second <= 1'b0;
            irq                   <= 1'b0;
            main_osc_en           <= 1'b0;
            core_run              <= 1'b0;
            mem_active            <= 1'b0;
            mem_ctl_release       <= 1'b0;
            memory_address_lines_weak_low <= 1'b1;
            dev_mode              <= 2'h0;
        end else begin
            mode                  <= next_mode;
            sec                   <= next_sec;
            mins                  <= next_mins;
            hrs                   <= next_hrs;
            days                  <= next_days;
            tick                  <= next_tick;
            sps_ctl               <= next_sps_ctl;
            pd_bit                <= next_pd_bit;
            hw_cfg0               <= next_hw_cfg0;
            hw_cfg2               <= next_hw_cfg2;
            int_mask              <= next_int_mask;
            stat_old              <= stat_s2;
            rdata                 <= next_rdata;
            special_output_first  <= next_sp0;
            special_output_second <= next_sp1;
            irq                   <= next_irq;
            main_osc_en           <= (next_mode == SMC_ACTIVE);
            core_run              <= (next_mode == SMC_ACTIVE);
            // Memory activity in active mode, or refresh in power-down on aux osc
            mem_active            <= (next_mode == SMC_ACTIVE) ||
                                     ((next_mode == SMC_PDOWN) && osc_s2 && hw_cfg0[CFG0_OSC_BIT] &&
                                      (hw_cfg2[CFG2_AUDIO_GRADE_DRAM_BIT] || hw_cfg2[CFG2_APP_BIT]));
            mem_ctl_release       <= (next_mode == SMC_PDOWN) && hw_cfg2[CFG2_PPM_BIT];
            memory_address_lines_weak_low <= !((next_mode == SMC_ACTIVE) && (mau_s2 || hw_cfg2[CFG2_APP_BIT]));
            dev_mode              <= next_mode;
        end
    end

endmodule

// ===== smc_top_chk.sv
// Checker for smc_top: mode sequencing and register port relations
// Assumes it is bound into smc_top and sees only that module's ports
`timescale 1ns/1ps
module smc_top_chk
    import smc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        irq,
    input wire logic        main_osc_en,
    input wire logic        core_run,
    input wire logic        mem_active,
    input wire logic        mem_ctl_release,
    input wire logic        memory_address_lines_weak_low,
    input wire logic [1:0]  dev_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // Host access to an address up to ADDR_STATUS; strobes elsewhere, ADDR_MODE included, are left unjudged
    logic acc;
    assign acc = (wr || rd) && (addr <= ADDR_STATUS);

    property p_reset_halt;
        dev_mode == 2'h0 |-> !core_run && !mem_active && !main_osc_en;
    endproperty
    a_reset_halt: assert property (p_reset_halt) else $error("activity while in reset mode");
    property p_weak_low;
        dev_mode != 2'h1 |-> memory_address_lines_weak_low;
    endproperty
    a_weak_low: assert property (p_weak_low) else $error("address lines driven outside active mode");
    property p_rdata;
        rdata != 16'h0000 |-> $past(rd);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data without a read strobe");
    property p_first_access;
        dev_mode == 2'h0 && acc |-> ##2 dev_mode == 2'h1;
    endproperty
    a_first_access: assert property (p_first_access) else $error("first access did not leave reset mode");
    // Only a quiet port after the write is judged; a wake access would race it
    property p_pd_enter;
        (wr && addr == ADDR_CHIP_CTL && wdata[0] && dev_mode == 2'h1) ##1 (!wr && !rd) [*2] |=> dev_mode == 2'h2;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("power-down write not taken");
    property p_pd_osc;
        dev_mode == 2'h2 |-> !main_osc_en && !core_run;
    endproperty
    a_pd_osc: assert property (p_pd_osc) else $error("main oscillator running in power-down");
    property p_release;
        mem_ctl_release |-> dev_mode == 2'h2;
    endproperty
    a_release: assert property (p_release) else $error("control lines released outside power-down");
    property p_wake;
        dev_mode == 2'h2 && acc |-> ##[1:3] dev_mode == 2'h1;
    endproperty
    a_wake: assert property (p_wake) else $error("access in power-down did not wake");

    c_first: cover property (dev_mode == 2'h0 && acc);
    c_pdown: cover property (dev_mode == 2'h2);
    c_irq: cover property (irq);
endmodule

bind smc_top smc_top_chk i_chk (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .main_osc_en(main_osc_en), .core_run(core_run), .mem_active(mem_active),
    .mem_ctl_release(mem_ctl_release), .memory_address_lines_weak_low(memory_address_lines_weak_low),
    .dev_mode(dev_mode));

// ===== smc_top_tb.sv
// Testbench for smc_top: registers, output mux, modes and interrupt
// Assumes a 25 MHz clock and the host model for the register port
`timescale 1ns/1ps
module smc_top_tb;
    import smc_pkg::*;
    typedef struct packed { logic [3:0] a; logic [15:0] d; logic [15:0] e; } smc_reg_row_t;
    typedef struct packed { logic [8:0] ctl; logic [15:0] st; logic sp; logic [1:0] ext; logic [1:0] e; } smc_sps_row_t;
    logic core_clk, nrst, wr, rd, aux_osc_run, spkr_status, mem_addr_used;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, status_in, d;
    logic [1:0]  prompt_ext_addr, dev_mode;
    logic        sp_first, sp_second, irq, main_osc_en, core_run, mem_active, mem_ctl_release, weak_low;
    int          miscompares, check_count, cycles, n;
    // Write rows read back whole; the unmapped place reads zero
    smc_reg_row_t regs [7] = '{'{ADDR_TIME_SM, 16'h0EFB, 16'h0EFB}, '{ADDR_TIME_HD, 16'hFFF7, 16'hFFF7},
        '{ADDR_SPS_CTL, 16'h01FF, 16'h01FF}, '{ADDR_HW_CFG0, 16'h0003, 16'h0003},
        '{ADDR_HW_CFG2, 16'h0003, 16'h0003}, '{ADDR_INT_MASK, 16'hFFFF, 16'hFFFF}, '{4'hF, 16'h1234, 16'h0000}};
    // Mux rows: all eight mode codes, window edges and the ready bit
    smc_sps_row_t sps [11] = '{'{9'h001, 16'h0000, 1'b0, 2'h0, 2'h2}, '{9'h002, 16'h0000, 1'b0, 2'h0, 2'h1},
        '{9'h004, 16'h0000, 1'b1, 2'h0, 2'h2}, '{9'h008, 16'h0000, 1'b0, 2'h3, 2'h3},
        '{9'h06C, 16'h0010, 1'b0, 2'h0, 2'h1}, '{9'h1CC, 16'hC000, 1'b0, 2'h0, 2'h2},
        '{9'h1EC, 16'hFFFF, 1'b0, 2'h0, 2'h0}, '{9'h013, 16'hFFFF, 1'b1, 2'h3, 2'h0},
        '{9'h017, 16'hFFFF, 1'b1, 2'h3, 2'h0}, '{9'h01B, 16'hFFFF, 1'b1, 2'h3, 2'h0},
        '{9'h01F, 16'hFFFF, 1'b1, 2'h3, 2'h0}};

    smc_host h (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    smc_top i_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .aux_osc_run(aux_osc_run), .status_in(status_in), .spkr_status(spkr_status),
        .prompt_ext_addr(prompt_ext_addr), .mem_addr_used(mem_addr_used), .special_output_first(sp_first),
        .special_output_second(sp_second), .irq(irq), .main_osc_en(main_osc_en), .core_run(core_run),
        .mem_active(mem_active), .mem_ctl_release(mem_ctl_release), .memory_address_lines_weak_low(weak_low),
        .dev_mode(dev_mode));

    // 40 ns clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Watchdog; the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Inputs pass two sync flops and a register, so let them land
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask
    // Pulses seen over a quiet stretch
    task automatic count_irq(output int c);
        c = 0;
        repeat (8) begin
            @(posedge core_clk);
            if (irq !== 1'b0) c++; // An unknown counts as a pulse, so it cannot pass a quiet check
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        nrst            = 1'b0;
        aux_osc_run     = 1'b0;
        status_in       = 16'h0000;
        spkr_status     = 1'b0;
        prompt_ext_addr = 2'h0;
        mem_addr_used   = 1'b0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk({10'h000, weak_low, dev_mode, main_osc_en, mem_ctl_release, mem_active}, 16'h0020);
        h.put(ADDR_HW_CFG2, 16'h0001);
        settle();
        chk({11'h000, dev_mode, main_osc_en, mem_ctl_release, mem_active}, 16'h000D);
        h.get(ADDR_HW_CFG2, d);
        chk(d, 16'h0001);
        foreach (regs[i]) begin
            h.put(regs[i].a, regs[i].d);
            h.get(regs[i].a, d);
            chk(d, regs[i].e);
        end
        mem_addr_used <= 1'b1;
        settle();
        chk({15'h0000, weak_low}, 16'h0000);
        foreach (sps[i]) begin
            h.put(ADDR_SPS_CTL, {7'h00, sps[i].ctl});
            status_in       <= sps[i].st;
            spkr_status     <= sps[i].sp;
            prompt_ext_addr <= sps[i].ext;
            settle();
            chk({14'h0000, sp_first, sp_second}, {14'h0000, sps[i].e});
        end
        h.put(ADDR_INT_MASK, 16'h0002);
        settle();
        status_in <= 16'hFFFD;
        count_irq(n);
        chk(16'(n), 16'h0001);
        status_in <= 16'hFFF9;
        count_irq(n);
        chk(16'(n), 16'h0000);
        status_in <= 16'hFFF8;
        count_irq(n);
        chk(16'(n), 16'h0001);
        aux_osc_run <= 1'b1;
        h.put(ADDR_CHIP_CTL, 16'h0001);
        settle();
        chk({11'h000, dev_mode, main_osc_en, mem_ctl_release, mem_active}, 16'h0013);
        h.get(ADDR_STATUS, d);
        chk(d, 16'hFFF8);
        settle();
        chk({11'h000, dev_mode, main_osc_en, mem_ctl_release, mem_active}, 16'h000D);
        h.get(ADDR_CHIP_CTL, d);
        chk(d, 16'h0000);
        h.get(ADDR_MODE, d);
        chk(d, 16'h0001);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        h.put(ADDR_CHIP_CTL, 16'h0001);
        settle();
        chk({11'h000, dev_mode, main_osc_en, mem_ctl_release, mem_active}, 16'h000D);
        h.get(ADDR_INT_MASK, d);
        chk(d, 16'h0000);
        h.get(ADDR_HW_CFG2, d);
        chk(d, 16'h0000);
        wrap_up();
    end
endmodule
